// file: rmac_pkg.sv
// Package: constants and types for receive-mode and ranging-address control
`default_nettype none
package rmac_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] MREQ_B3_OFS = 12'h912;
  localparam logic [11:0] MREQ_B2_OFS = 12'h913;
  localparam logic [11:0] MREQ_B1_OFS = 12'h914;
  localparam logic [11:0] MREQ_B0_OFS = 12'h915;
  localparam logic [11:0] SRSP_B3_OFS = 12'h916;
  localparam logic [11:0] SRSP_B2_OFS = 12'h917;
  localparam logic [11:0] SRSP_B1_OFS = 12'h918;
  localparam logic [11:0] SRSP_B0_OFS = 12'h919;
  localparam logic [11:0] CMPW_OFS    = 12'h931;
  localparam logic [11:0] SYNC_HI_OFS = 12'h944;
  localparam logic [11:0] SYNC_LO_OFS = 12'h945;
  localparam logic [11:0] FERR_H_OFS  = 12'h954;
  localparam logic [11:0] FERR_M_OFS  = 12'h955;
  localparam logic [11:0] FERR_L_OFS  = 12'h956;
  // ---------------------------------------------------------------
  // Field positions and special values
  // ---------------------------------------------------------------
  localparam int          CMPW_MSB     = 7;
  localparam int          CMPW_LSB     = 6;
  localparam logic [15:0] TMO_SINGLE   = 16'h0000;
  localparam logic [15:0] TMO_CONT     = 16'hffff;
  localparam int          NFLAGS       = 7;
  // Flag bit positions
  localparam int          FLG_RECEIVE_COMPLETE_FLAG   = 0;
  localparam int          FLG_PREAMBLE = 1;
  localparam int          FLG_SYNC     = 2;
  localparam int          FLG_HDR_OK   = 3;
  localparam int          FLG_HDR_BAD  = 4;
  localparam int          FLG_CRC      = 5;
  localparam int          FLG_TIMEOUT  = 6;
  // Timeout step: one step per this many clocks (1 us at 125 MHz)
  localparam int          CLK_MHZ      = 125;
  localparam int          STEP_NS      = 1000;
  localparam int          STEP_CYC     = (STEP_NS * CLK_MHZ) / 1000;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STBY = 3'b001,
    ST_RX   = 3'b010,
    ST_PKT  = 3'b100
  } rmac_state_e;
  // Receiver events from the modem
  typedef struct packed {
    logic        preamble;
    logic        sync;
    logic        hdr_ok;
    logic        hdr_bad;
    logic        pkt_start;
    logic        pkt_end;
    logic        crc_bad;
    logic [7:0]  length;
    logic [7:0]  start_ofs;
    logic [7:0]  snr_x4;
    logic [19:0] freq_err;
    logic [31:0] req_addr;
    logic        req_valid;
  } rmac_rxev_s;
  // Register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } rmac_reg_s;
endpackage
`default_nettype wire

// file: rmac_addr_cmp.sv
// Ranging request address comparator with selectable width
`timescale 1ns/1ps
`default_nettype none
module rmac_addr_cmp (
  // Operands
  input  wire logic [31:0] own_addr,
  input  wire logic [31:0] req_addr,
  input  wire logic [1:0]  width_code,
  // Result
  output logic             match
);
  logic [31:0] mask;
  assign mask  = {{8{width_code == 2'h3}}, {8{width_code >= 2'h2}},
                  {8{width_code >= 2'h1}}, 8'hff};
  assign match = ((own_addr ^ req_addr) & mask) == 32'h0000_0000;
endmodule
`default_nettype wire

// file: rmac_top.sv
// Receive-mode sequencing, receive flags, status readout and ranging address match
`timescale 1ns/1ps
`default_nettype none
module rmac_top #(
  parameter int STEP_CYCLES = rmac_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  // Host commands
  input  wire logic               ENTER_RX,
  input  wire logic [15:0]        TIMEOUT_COUNT,
  input  wire logic               GO_STANDBY,
  input  wire logic               CLEAR_FLAGS,
  input  wire logic [6:0]         CLEAR_MASK,
  input  wire logic               ROUTE_WR,
  input  wire logic [6:0]         ROUTE_DIO1,
  input  wire logic [6:0]         ROUTE_DIO2,
  input  wire logic [6:0]         ROUTE_DIO3,
  input  wire logic               IQ_INVERTED,
  input  wire logic               CARRIER_WR,
  input  wire logic [23:0]        CARRIER_STEPS,
  // Register access
  input  wire rmac_pkg::rmac_reg_s REG_REQ,
  output logic [7:0]              REG_RDATA,
  output logic                    REG_RVALID,
  // Modem events
  input  wire rmac_pkg::rmac_rxev_s RX_EV,
  // State and flags
  output logic                    RX_ACTIVE,
  output logic [6:0]              FLAGS,
  output logic                    DIO1,
  output logic                    DIO2,
  output logic                    DIO3,
  // Status readout
  output logic [7:0]              PKT_SNR,
  output logic [7:0]              RX_LENGTH,
  output logic [7:0]              RX_START_OFS,
  output logic [23:0]             CARRIER_Q,
  output logic [31:0]             MASTER_ADDR,
  output logic                    RESPOND,
  output logic                    DISCARD
);
  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  rmac_pkg::rmac_state_e state_q, state_d;
  logic [15:0] tmo_q;
  logic        cont_q;
  logic        timed_q;
  logic [15:0] steps_q;
  logic [$clog2(STEP_CYCLES+1)-1:0] div_q;
  logic [6:0]  flags_q;
  logic [6:0]  r1_q, r2_q, r3_q;
  logic [7:0]  mreq_q [4];
  logic [7:0]  srsp_q [4];
  logic [7:0]  cmpw_q;
  logic [7:0]  sync_hi_q, sync_lo_q;
  logic [19:0] ferr_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [7:0]  snr_q, len_q, ofs_q;
  logic [23:0] carrier_q;
  logic        respond_q, discard_q;
  logic        rx_active_q;
  // ---------------------------------------------------------------
  // Timer decode
  // ---------------------------------------------------------------
  wire step_tick = (div_q == ($bits(div_q))'(STEP_CYCLES - 1));
  // Expiry on the last step; the counter is held clear outside search
  wire tmo_expire = (state_q == rmac_pkg::ST_RX) && timed_q && step_tick &&
                    (steps_q == tmo_q - 16'h0001);
  wire in_rx = (state_q != rmac_pkg::ST_STBY);
  wire pkt_end = in_rx && RX_EV.pkt_end;
  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rmac_pkg::ST_STBY: begin
        if (ENTER_RX) state_d = rmac_pkg::ST_RX;
      end
      rmac_pkg::ST_RX: begin
        if (GO_STANDBY) state_d = rmac_pkg::ST_STBY;
        else if (RX_EV.pkt_start) state_d = rmac_pkg::ST_PKT;
        else if (RX_EV.pkt_end && !cont_q) state_d = rmac_pkg::ST_STBY;
        else if (tmo_expire) state_d = rmac_pkg::ST_STBY;
      end
      rmac_pkg::ST_PKT: begin
        if (GO_STANDBY) state_d = rmac_pkg::ST_STBY;
        else if (RX_EV.pkt_end) begin
          if (cont_q) state_d = rmac_pkg::ST_RX;
          else state_d = rmac_pkg::ST_STBY;
        end
      end
      default: state_d = rmac_pkg::ST_STBY;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) state_q <= rmac_pkg::ST_STBY;
    else state_q <= state_d;
  end

  // Receive indication taken from the next state, same timing as the state
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) rx_active_q <= 1'b0;
    else rx_active_q <= (state_d != rmac_pkg::ST_STBY);
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tmo_q   <= 16'h0000;
      cont_q  <= 1'b0;
      timed_q <= 1'b0;
    end else if (ENTER_RX && state_q == rmac_pkg::ST_STBY) begin
      tmo_q   <= TIMEOUT_COUNT;
      cont_q  <= (TIMEOUT_COUNT == rmac_pkg::TMO_CONT);
      timed_q <= (TIMEOUT_COUNT != rmac_pkg::TMO_SINGLE) &&
                 (TIMEOUT_COUNT != rmac_pkg::TMO_CONT);
    end
  end

  // ---------------------------------------------------------------
  // Step timer, run only while searching
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_q   <= '0;
      steps_q <= 16'h0000;
    end else if (state_q != rmac_pkg::ST_RX || !timed_q) begin
      div_q   <= '0;
      steps_q <= 16'h0000;
    end else if (step_tick) begin
      div_q   <= '0;
      steps_q <= steps_q + 16'h0001;
    end else begin
      div_q   <= div_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Flags: set wins over clear
  // ---------------------------------------------------------------
  logic [6:0] set_v;
  always_comb begin
    set_v = 7'h00;
    set_v[rmac_pkg::FLG_RECEIVE_COMPLETE_FLAG]   = pkt_end;
    set_v[rmac_pkg::FLG_PREAMBLE] = in_rx && RX_EV.preamble;
    set_v[rmac_pkg::FLG_SYNC]     = in_rx && RX_EV.sync;
    set_v[rmac_pkg::FLG_HDR_OK]   = in_rx && RX_EV.hdr_ok;
    set_v[rmac_pkg::FLG_HDR_BAD]  = in_rx && RX_EV.hdr_bad;
    set_v[rmac_pkg::FLG_CRC]      = pkt_end && RX_EV.crc_bad;
    set_v[rmac_pkg::FLG_TIMEOUT]  = tmo_expire && !RX_EV.pkt_start && !RX_EV.pkt_end;
  end

  // A flag set in the same cycle as its clear stays set
  wire [6:0] clr_v = CLEAR_FLAGS ? CLEAR_MASK : 7'h00;
  wire [6:0] flags_d = set_v | (flags_q & ~clr_v);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) flags_q <= 7'h00;
    else flags_q <= flags_d;
  end

  // ---------------------------------------------------------------
  // Flag routing to pins
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      r1_q <= 7'h00;
      r2_q <= 7'h00;
      r3_q <= 7'h00;
    end else if (ROUTE_WR) begin
      r1_q <= ROUTE_DIO1;
      r2_q <= ROUTE_DIO2;
      r3_q <= ROUTE_DIO3;
    end
  end

  // Pins follow next flag value so they drop with the clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DIO1 <= 1'b0;
      DIO2 <= 1'b0;
      DIO3 <= 1'b0;
    end else begin
      DIO1 <= |(flags_d & r1_q);
      DIO2 <= |(flags_d & r2_q);
      DIO3 <= |(flags_d & r3_q);
    end
  end

  // ---------------------------------------------------------------
  // Packet status capture
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      snr_q  <= 8'h00;
      len_q  <= 8'h00;
      ofs_q  <= 8'h00;
      ferr_q <= 20'h00000;
    end else if (pkt_end) begin
      snr_q  <= RX_EV.snr_x4;
      len_q  <= RX_EV.length;
      ofs_q  <= RX_EV.start_ofs;
      ferr_q <= IQ_INVERTED ? 20'h00000 - RX_EV.freq_err : RX_EV.freq_err;
    end
  end

  // ---------------------------------------------------------------
  // Carrier setting
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) carrier_q <= 24'h000000;
    else if (CARRIER_WR) carrier_q <= CARRIER_STEPS;
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  wire wr = REG_REQ.wr;
  wire [11:0] a = REG_REQ.addr;
  wire [7:0]  wd = REG_REQ.wdata;

  wire hit_cmpw    = (a == rmac_pkg::CMPW_OFS);
  wire hit_sync_hi = (a == rmac_pkg::SYNC_HI_OFS);
  wire hit_sync_lo = (a == rmac_pkg::SYNC_LO_OFS);
  wire hit_ferr_h  = (a == rmac_pkg::FERR_H_OFS);
  wire hit_ferr_m  = (a == rmac_pkg::FERR_M_OFS);
  wire hit_ferr_l  = (a == rmac_pkg::FERR_L_OFS);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        mreq_q[i] <= 8'h00;
        srsp_q[i] <= 8'h00;
      end
      cmpw_q    <= 8'h00;
      sync_hi_q <= 8'h00;
      sync_lo_q <= 8'h00;
    end else if (wr) begin
      for (int i = 0; i < 4; i++) begin
        if (a == rmac_pkg::MREQ_B3_OFS + 12'(i)) mreq_q[i] <= wd;
        if (a == rmac_pkg::SRSP_B3_OFS + 12'(i)) srsp_q[i] <= wd;
      end
      if (hit_cmpw) cmpw_q <= wd;
      if (hit_sync_hi) sync_hi_q <= {wd[7:4], sync_hi_q[3:0]};
      if (hit_sync_lo) sync_lo_q <= {wd[7:4], sync_lo_q[3:0]};
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (a == rmac_pkg::MREQ_B3_OFS + 12'(i)) rd_mux = mreq_q[i];
      if (a == rmac_pkg::SRSP_B3_OFS + 12'(i)) rd_mux = srsp_q[i];
    end
    if (hit_cmpw) rd_mux = cmpw_q;
    if (hit_sync_hi) rd_mux = sync_hi_q;
    if (hit_sync_lo) rd_mux = sync_lo_q;
    if (hit_ferr_h) rd_mux = {{4{ferr_q[19]}}, ferr_q[19:16]};
    if (hit_ferr_m) rd_mux = ferr_q[15:8];
    if (hit_ferr_l) rd_mux = ferr_q[7:0];
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= REG_REQ.rd ? rd_mux : rdata_q;
      rvalid_q <= REG_REQ.rd;
    end
  end

  // ---------------------------------------------------------------
  // Ranging request address check
  // ---------------------------------------------------------------
  logic addr_match;
  rmac_addr_cmp u_cmp (
    .own_addr   ({srsp_q[0], srsp_q[1], srsp_q[2], srsp_q[3]}),
    .req_addr   (RX_EV.req_addr),
    .width_code (cmpw_q[rmac_pkg::CMPW_MSB:rmac_pkg::CMPW_LSB]),
    .match      (addr_match)
  );

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      respond_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      respond_q <= in_rx && RX_EV.req_valid && addr_match;
      discard_q <= in_rx && RX_EV.req_valid && !addr_match;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RX_ACTIVE    = rx_active_q;
  assign FLAGS        = flags_q;
  assign PKT_SNR      = snr_q;
  assign RX_LENGTH    = len_q;
  assign RX_START_OFS = ofs_q;
  assign CARRIER_Q    = carrier_q;
  assign MASTER_ADDR  = {mreq_q[0], mreq_q[1], mreq_q[2], mreq_q[3]};
  assign REG_RDATA    = rdata_q;
  assign REG_RVALID   = rvalid_q;
  assign RESPOND      = respond_q;
  assign DISCARD      = discard_q;
endmodule
`default_nettype wire

// file: rmac_top_properties.sv
// Concurrent checks on the receive-control top ports
`timescale 1ns/1ps
`default_nettype none
module rmac_top_chk (
  // Clock and reset
  input wire logic                 CLK_SYS,
  input wire logic                 RST,
  // Commands
  input wire logic                 ENTER_RX,
  input wire logic [15:0]          TIMEOUT_COUNT,
  input wire logic                 GO_STANDBY,
  input wire logic                 CLEAR_FLAGS,
  input wire logic [6:0]           CLEAR_MASK,
  input wire logic                 ROUTE_WR,
  input wire logic [6:0]           ROUTE_DIO1,
  input wire rmac_pkg::rmac_reg_s  REG_REQ,
  input wire rmac_pkg::rmac_rxev_s RX_EV,
  // Results
  input wire logic                 REG_RVALID,
  input wire logic                 RX_ACTIVE,
  input wire logic [6:0]           FLAGS,
  input wire logic                 DIO1,
  input wire logic                 RESPOND,
  input wire logic                 DISCARD
);
  logic       cont_q;
  logic [6:0] r1_q;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cont_q <= 1'b0;
      r1_q   <= 7'h00;
    end else begin
      if (ENTER_RX && !RX_ACTIVE) cont_q <= (TIMEOUT_COUNT == 16'hffff);
      if (ROUTE_WR) r1_q <= ROUTE_DIO1;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_rd;
    REG_REQ.rd ##1 !REG_REQ.rd |-> REG_RVALID ##1 !REG_RVALID;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read valid not one cycle");
  property p_enter;
    ENTER_RX && !RX_ACTIVE && !GO_STANDBY |=> RX_ACTIVE;
  endproperty
  a_enter: assert property (p_enter)
    else $error("receive not entered");
  property p_single;
    RX_ACTIVE && !cont_q && RX_EV.pkt_end |=> $fell(RX_ACTIVE);
  endproperty
  a_single: assert property (p_single)
    else $error("no standby after packet");
  property p_cont;
    RX_ACTIVE && cont_q && RX_EV.pkt_end && !GO_STANDBY |=> RX_ACTIVE && FLAGS[0];
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous receive left");
  property p_crc;
    RX_ACTIVE && RX_EV.pkt_end && RX_EV.crc_bad |=> FLAGS[5] && FLAGS[0];
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc or done flag missing");
  property p_clear;
    CLEAR_FLAGS && !RX_ACTIVE |=> FLAGS == ($past(FLAGS) & ~$past(CLEAR_MASK));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear mask misapplied");
  property p_dio;
    DIO1 == |(FLAGS & $past(r1_q));
  endproperty
  a_dio: assert property (p_dio)
    else $error("output pin not OR of flags");
  property p_resp;
    RX_ACTIVE && RX_EV.req_valid |=> RESPOND ^ DISCARD;
  endproperty
  a_resp: assert property (p_resp)
    else $error("request not decided");
endmodule
bind rmac_top rmac_top_chk u_chk (
  .CLK_SYS, .RST, .ENTER_RX, .TIMEOUT_COUNT, .GO_STANDBY, .CLEAR_FLAGS, .CLEAR_MASK,
  .ROUTE_WR, .ROUTE_DIO1, .REG_REQ, .RX_EV, .REG_RVALID, .RX_ACTIVE, .FLAGS, .DIO1,
  .RESPOND, .DISCARD
);
`default_nettype wire

// file: rmac_host_model.sv
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module rmac_host_model (
  // Register port
  input  wire logic           clk,
  output var rmac_pkg::rmac_reg_s req,
  input  wire logic [7:0]     rdata,
  input  wire logic           rvalid
);
  initial req = '0;
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    req = {2'b10, a, d};
    @(negedge clk);
    req = {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    req = {2'b01, a, 8'h00};
    @(negedge clk);
    req = {2'b00, ~a, 8'hff};
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for receive control and ranging match
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int STEP = 2;
  logic        clk, rst, enter, gostb, clr, rwr, iq, cwr, act, rv, resp, disc, d1, d2, d3;
  logic [15:0] tmo;
  logic [6:0]  cmask, r1, r2, r3, flags, ef;
  logic [23:0] steps, carq, fx;
  logic [31:0] maddr, sa;
  logic [7:0]  rdat, snr, len, ofs, b;
  logic [19:0] fe;
  rmac_pkg::rmac_reg_s  req;
  rmac_pkg::rmac_rxev_s ev, last;
  int          miscompares = 0;
  int          checked = 0;
  rmac_top #(.STEP_CYCLES(STEP)) dut (
    .CLK_SYS(clk), .RST(rst), .ENTER_RX(enter), .TIMEOUT_COUNT(tmo), .GO_STANDBY(gostb),
    .CLEAR_FLAGS(clr), .CLEAR_MASK(cmask), .ROUTE_WR(rwr), .ROUTE_DIO1(r1), .ROUTE_DIO2(r2),
    .ROUTE_DIO3(r3), .IQ_INVERTED(iq), .CARRIER_WR(cwr), .CARRIER_STEPS(steps),
    .REG_REQ(req), .REG_RDATA(rdat), .REG_RVALID(rv), .RX_EV(ev), .RX_ACTIVE(act),
    .FLAGS(flags), .DIO1(d1), .DIO2(d2), .DIO3(d3), .PKT_SNR(snr), .RX_LENGTH(len),
    .RX_START_OFS(ofs), .CARRIER_Q(carq), .MASTER_ADDR(maddr), .RESPOND(resp), .DISCARD(disc)
  );
  rmac_host_model host (.clk(clk), .req(req), .rdata(rdat), .rvalid(rv));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start_rx(input logic [15:0] t);
    tick(1);
    enter = 1;
    tmo = t;
    tick(1);
    enter = 0;
  endtask
  // Modem strobes for one cycle, fresh random data, then scrambled
  task automatic modem(input logic [6:0] s, input logic [31:0] ra, input logic rq);
    tick(1);
    ev = {s, 76'({$urandom, $urandom, $urandom}), rq};
    ev.req_addr = ra;
    last = ev;
    tick(1);
    ev = {7'h00, ~last[76:1], 1'b0};
  endtask
  task automatic clear(input logic [6:0] m);
    tick(1);
    clr = 1;
    cmask = m;
    tick(1);
    clr = 0;
    cmask = ~m;
    ef = ef & ~m;
  endtask
  task automatic chk_flags;
    chk("flags", 32'(ef), 32'(flags));
    chk("dio", {|(ef & r1), |(ef & r2), |(ef & r3)}, {d1, d2, d3});
  endtask
  task automatic fei_chk;
    fx = {{4{fe[19]}}, fe};
    for (int i = 0; i < 3; i++) begin
      host.rd(12'h954 + 12'(i), b);
      chk("fei", fx[23 - 8 * i -: 8], b);
    end
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 5000);
    miscompares++;
    give_verdict();
  end
  initial begin
    {rst, enter, gostb, clr, rwr, iq, cwr} = 7'h40;
    {tmo, cmask, r1, r2, r3, steps, ef} = '0;
    ev = '0;
    void'($urandom(18589));
    tick(12);
    rst = 0;
    {r1, r2, r3} = 21'($urandom);
    steps = 24'($urandom);
    {rwr, cwr} = 2'b11;
    tick(1);
    {rwr, cwr} = 2'b00;
    chk("carrier", 32'(steps), 32'(carq));
    sa = $urandom;
    for (int i = 0; i < 4; i++) host.wr(12'h912 + 12'(i), sa[31 - 8 * i -: 8]);
    chk("master_addr", sa, maddr);
    host.wr(12'h944, 8'hb7);
    host.wr(12'h954, 8'h5a);
    host.rd(12'h944, b);
    chk("sync_hi", 8'hb0, b);
    host.wr(12'h945, 8'h3c);
    host.rd(12'h945, b);
    chk("sync_lo", 8'h30, b);
    host.rd(12'h900, b);
    chk("unmapped", 0, b);
    // Single receive with inverted IQ
    iq = 1;
    start_rx(16'h0000);
    modem(7'h70, 0, 0);
    tick(40);
    chk("active", 1, act);
    modem(7'h04, 0, 0);
    modem(7'h03, 0, 0);
    ef = 7'h2f;
    chk("active", 0, act);
    chk_flags();
    chk("snr", last.snr_x4, snr);
    chk("buf", {last.start_ofs, last.length}, {ofs, len});
    fe = -last.freq_err;
    fei_chk();
    clear(7'($urandom));
    chk_flags();
    clear(7'h7f);
    // Continuous receive and address compare widths
    iq = 0;
    start_rx(16'hffff);
    modem(7'h08, 0, 0);
    modem(7'h02, 0, 0);
    modem(7'h02, 0, 0);
    ef = 7'h11;
    chk("active", 1, act);
    chk_flags();
    fe = last.freq_err;
    fei_chk();
    for (int w = 0; w < 4; w++) begin
      sa = $urandom;
      for (int i = 0; i < 4; i++) host.wr(12'h916 + 12'(i), sa[31 - 8 * i -: 8]);
      host.wr(12'h931, {2'(w), 6'($urandom)});
      modem(7'h00, sa ^ (32'h1 << (8 * w + 8)), 1'b1);
      chk("respond", 2'b10, {resp, disc});
      modem(7'h00, sa ^ (32'h1 << (8 * w + 7)), 1'b1);
      chk("discard", 2'b01, {resp, disc});
    end
    chk("active", 1, act);
    start_rx(16'h0000);
    modem(7'h02, 0, 0);
    chk("active", 1, act);
    tick(1);
    gostb = 1;
    tick(1);
    gostb = 0;
    chk("active", 0, act);
    clear(7'h7f);
    // Timed receive: expiry, then timer stopped by a packet
    start_rx(16'h0003);
    tick(3 * STEP - 1);
    chk("active", 1, act);
    tick(1);
    ef = 7'h40;
    chk("active", 0, act);
    chk_flags();
    clear(7'h7f);
    start_rx(16'h0003);
    modem(7'h04, 0, 0);
    tick(12 * STEP);
    chk("active", 1, act);
    modem(7'h02, 0, 0);
    ef = 7'h01;
    chk("active", 0, act);
    chk_flags();
    give_verdict();
  end
endmodule
`default_nettype wire
